// ---- core/timer_group.sv ----
// Timer group: bus watchdog, wake-up timer, calendar clock, windowed
// watchdog and two general count-down timers behind an APB slave.
// Assumes pclk at 100 MHz; the two slow clocks arrive as asynchronous pins.
`timescale 1ns/100ps
`include "timer_group_defs.svh"

// Function
// - Reset device after 4 or 8 s without access
// - Periodic wake, 125 ms to 8 s
// - 24-bit clock reachable on the bus
// - Clock from free-running clock, divider up to 65536
// - Clock counts seconds to days since enable
// - Alarm match raises enabled interrupt
// - Watchdog expiry forces power-on reset
// - Watchdog clock selectable, divider up to 65536
// - Restart accepted only inside window
// - Watchdog interrupt enable and full disable
// - Watchdog usable for interval or wake
// - Two 24-bit general timers on the bus
// - Timers count down, divider up to 32768
// - Timer interrupt at zero when enabled
module timer_group #(
  parameter int MS_CYCLES = `MS_NS / `PCLK_NS,
  parameter int GT_WIDTH  = 24,
  parameter int GT_DIV_W  = 15
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Slow clock pins and bus activity
  input  wire logic        free_running_clock,
  input  wire logic        ring_oscillator_clock,
  input  wire logic        analog_front_end_access,
  // Events to the system
  output logic             afe_wd_reset,
  output logic             windowed_watchdog_por_req,
  output logic             wake_pulse,
  output logic             rtc_irq,
  output logic             windowed_watchdog_irq,
  output logic [1:0]       gt_irq
);

  if (MS_CYCLES < 2 || GT_WIDTH != 24 || GT_DIV_W < 1 || GT_DIV_W > 15) begin : g_bad
    $error("timer_group: unsupported parameter");
  end

  localparam int MSW = $clog2(MS_CYCLES);

  function automatic logic [15:0] div_step(input logic [15:0] cnt,
                                           input logic [15:0] ratio,
                                           input logic        tick);
    if (!tick) return cnt;
    return (cnt == ratio) ? 16'h0000 : cnt + 16'h0001;
  endfunction : div_step

  // Register state
  timer_group_pkg::ctrl_t     ctrl,   next_ctrl;
  timer_group_pkg::flags_t    flags,  next_flags;
  timer_group_pkg::rtc_time_t alarm,  next_alarm;
  logic [15:0]                rtc_div, next_rtc_div;
  logic [15:0]                wd_div,  next_wd_div;
  logic [23:0]                wd_period, next_wd_period;
  logic [23:0]                wd_window, next_wd_window;
  logic [GT_WIDTH-1:0]        gt_load [2];
  logic [GT_WIDTH-1:0]        next_gt_load [2];
  logic [GT_DIV_W-1:0]        gt_div [2];
  logic [GT_DIV_W-1:0]        next_gt_div [2];
  logic [31:0]                next_prdata;
  timer_group_pkg::flags_t    set;
  logic                       wr;
  logic                       kick;
  logic                       mapped;

  // Engine state
  logic [2:0]                 sync_fr, sync_ro;
  logic [1:0]                 filt, filt_d, next_filt;
  logic [1:0]                 edge_tick;
  logic [MSW-1:0]             ms_cnt, next_ms_cnt;
  logic                       ms_tick;
  logic [13:0]                idle_ms, next_idle_ms;
  logic                       next_afe_wd_reset;
  logic [13:0]                wake_ms, next_wake_ms;
  logic [13:0]                wake_lim;
  logic [2:0]                 wsel;
  logic                       next_wake_pulse;
  logic [15:0]                rtc_pre, next_rtc_pre;
  logic [19:0]                usec, next_usec;
  timer_group_pkg::rtc_time_t tod, next_tod;
  logic                       us_tick;
  logic                       rtc_set;
  timer_group_pkg::wd_state_t wd_state, next_wd_state;
  logic [15:0]                wd_pre, next_wd_pre;
  logic [23:0]                wd_count, next_wd_count;
  logic                       wd_tick;
  logic                       wd_warn, wd_fault;
  logic [GT_WIDTH-1:0]        gt_count [2];
  logic [1:0]                 gt_zero;

  assign wr     = psel && penable && pwrite;
  assign kick   = wr && (paddr == `OFF_WINDOWED_WATCHDOG_KICK) && (pwdata == `WINDOWED_WATCHDOG_KEY);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    case (paddr)
      `OFF_CTRL, `OFF_STATUS, `OFF_RTC_DIV, `OFF_RTC_TIME, `OFF_RTC_ALARM,
      `OFF_WINDOWED_WATCHDOG_DIV, `OFF_WINDOWED_WATCHDOG_PERIOD, `OFF_WINDOWED_WATCHDOG_WINDOW, `OFF_WINDOWED_WATCHDOG_KICK,
      `OFF_GT0_LOAD, `OFF_GT0_DIV, `OFF_GT0_COUNT,
      `OFF_GT1_LOAD, `OFF_GT1_DIV, `OFF_GT1_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Register writes, status flags and read data
  always_comb begin
    next_ctrl      = ctrl;
    next_alarm     = alarm;
    next_rtc_div   = rtc_div;
    next_wd_div    = wd_div;
    next_wd_period = wd_period;
    next_wd_window = wd_window;
    next_gt_load   = gt_load;
    next_gt_div    = gt_div;
    next_prdata    = prdata;
    set            = '{windowed_watchdog_fault: wd_fault, gt1_zero: gt_zero[1],
                       gt0_zero: gt_zero[0], windowed_watchdog_warn: wd_warn,
                       rtc_alarm: rtc_set, wake: next_wake_pulse};
    next_flags     = flags;
    if (wr) begin
      case (paddr)
        `OFF_CTRL:        next_ctrl      = pwdata[`CTRL_W-1:0];
        `OFF_STATUS:      next_flags     = flags & ~pwdata[`FLAGS_W-1:0];
        `OFF_RTC_DIV:     next_rtc_div   = pwdata[15:0];
        `OFF_RTC_ALARM:   next_alarm     = pwdata[23:0];
        `OFF_WINDOWED_WATCHDOG_DIV:    next_wd_div    = pwdata[15:0];
        `OFF_WINDOWED_WATCHDOG_PERIOD: next_wd_period = pwdata[23:0];
        `OFF_WINDOWED_WATCHDOG_WINDOW: next_wd_window = pwdata[23:0];
        `OFF_GT0_LOAD:    next_gt_load[0] = pwdata[GT_WIDTH-1:0];
        `OFF_GT0_DIV:     next_gt_div[0]  = pwdata[GT_DIV_W-1:0];
        `OFF_GT1_LOAD:    next_gt_load[1] = pwdata[GT_WIDTH-1:0];
        `OFF_GT1_DIV:     next_gt_div[1]  = pwdata[GT_DIV_W-1:0];
        default: ;
      endcase
    end
    // A new event beats a clear in the same cycle
    next_flags = next_flags | set;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFF_CTRL:        next_prdata = {17'h00000, ctrl};
        `OFF_STATUS:      next_prdata = {26'h0000000, flags};
        `OFF_RTC_DIV:     next_prdata = {16'h0000, rtc_div};
        `OFF_RTC_TIME:    next_prdata = {8'h00, tod};
        `OFF_RTC_ALARM:   next_prdata = {8'h00, alarm};
        `OFF_WINDOWED_WATCHDOG_DIV:    next_prdata = {16'h0000, wd_div};
        `OFF_WINDOWED_WATCHDOG_PERIOD: next_prdata = {8'h00, wd_period};
        `OFF_WINDOWED_WATCHDOG_WINDOW: next_prdata = {8'h00, wd_window};
        `OFF_WINDOWED_WATCHDOG_KICK:   next_prdata = {8'h00, wd_count};
        `OFF_GT0_LOAD:    next_prdata = {8'h00, gt_load[0]};
        `OFF_GT0_DIV:     next_prdata = {17'h00000, gt_div[0]};
        `OFF_GT0_COUNT:   next_prdata = {8'h00, gt_count[0]};
        `OFF_GT1_LOAD:    next_prdata = {8'h00, gt_load[1]};
        `OFF_GT1_DIV:     next_prdata = {17'h00000, gt_div[1]};
        `OFF_GT1_COUNT:   next_prdata = {8'h00, gt_count[1]};
        default:          next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= `CTRL_RESET;
      flags     <= '0;
      alarm     <= '0;
      rtc_div   <= '0;
      wd_div    <= '0;
      wd_period <= `WINDOWED_WATCHDOG_PERIOD_RST;
      wd_window <= `WINDOWED_WATCHDOG_WINDOW_RST;
      gt_load   <= '{default: '0};
      gt_div    <= '{default: '0};
      prdata    <= '0;
    end else begin
      ctrl      <= next_ctrl;
      flags     <= next_flags;
      alarm     <= next_alarm;
      rtc_div   <= next_rtc_div;
      wd_div    <= next_wd_div;
      wd_period <= next_wd_period;
      wd_window <= next_wd_window;
      gt_load   <= next_gt_load;
      gt_div    <= next_gt_div;
      prdata    <= next_prdata;
    end
  end

  assign rtc_irq  = flags.rtc_alarm & ctrl.rtc_alarm_ie;
  assign windowed_watchdog_irq = flags.windowed_watchdog_warn & ctrl.windowed_watchdog_ie;
  assign gt_irq   = {flags.gt1_zero & ctrl.gt1_ie,
                     flags.gt0_zero & ctrl.gt0_ie};

  // Slow clocks: a rising edge counts once the second and third stages agree
  assign edge_tick = filt & ~filt_d;
  always_comb begin
    next_filt[0] = (sync_fr[1] == sync_fr[2]) ? sync_fr[2] : filt[0];
    next_filt[1] = (sync_ro[1] == sync_ro[2]) ? sync_ro[2] : filt[1];
  end

  // Millisecond base, bus watchdog and wake-up timer
  assign ms_tick  = (ms_cnt == MSW'(MS_CYCLES - 1));
  assign wsel     = (ctrl.wake_sel > `WAKE_SEL_MAX) ? `WAKE_SEL_MAX : ctrl.wake_sel;
  assign wake_lim = 14'(`WAKE_BASE_MS) << wsel;
  always_comb begin
    next_ms_cnt       = ms_tick ? '0 : ms_cnt + 1'b1;
    next_idle_ms      = idle_ms;
    next_afe_wd_reset = afe_wd_reset;
    if (analog_front_end_access) begin
      next_idle_ms = '0;
    end else if (ms_tick) begin
      next_idle_ms = idle_ms + 14'h0001;
      if (next_idle_ms >= (ctrl.bus_wd_long ? 14'(`BUSWD_LONG_MS)
                                            : 14'(`BUSWD_SHORT_MS))) begin
        next_afe_wd_reset = 1'b1;
      end
    end
    next_wake_ms    = wake_ms;
    next_wake_pulse = 1'b0;
    if (!ctrl.wake_en) begin
      next_wake_ms = '0;
    end else if (ms_tick) begin
      next_wake_ms = wake_ms + 14'h0001;
      if (next_wake_ms >= wake_lim) begin
        next_wake_ms    = '0;
        next_wake_pulse = 1'b1;
      end
    end
  end

  // Calendar clock on the free-running clock
  assign us_tick = ctrl.rtc_en && edge_tick[0] && (rtc_pre == rtc_div);
  always_comb begin
    next_rtc_pre = div_step(rtc_pre, rtc_div, ctrl.rtc_en && edge_tick[0]);
    next_usec    = usec;
    next_tod     = tod;
    rtc_set      = 1'b0;
    if (!ctrl.rtc_en) begin
      // Counting starts from zero at each enable
      next_rtc_pre = '0;
      next_usec    = '0;
      next_tod     = '0;
    end else if (us_tick) begin
      next_usec = (usec == `RTC_US_PER_SEC) ? 20'h00000 : usec + 20'h00001;
      if (usec == `RTC_US_PER_SEC) begin
        next_tod.sec = tod.sec + 6'h01;
        if (tod.sec == `RTC_SEC_MAX) begin
          next_tod.sec = '0;
          next_tod.min = tod.min + 6'h01;
          if (tod.min == `RTC_MIN_MAX) begin
            next_tod.min  = '0;
            next_tod.hour = tod.hour + 5'h01;
            if (tod.hour == `RTC_HOUR_MAX) begin
              next_tod.hour = '0;
              next_tod.day  = tod.day + 7'h01;
            end
          end
        end
        rtc_set = (next_tod == alarm);
      end
    end
  end

  // Windowed watchdog
  assign wd_tick = edge_tick[ctrl.windowed_watchdog_clk_sel] && (wd_pre == wd_div);
  assign windowed_watchdog_por_req = (wd_state == timer_group_pkg::WD_TRIP);
  always_comb begin
    next_wd_state = wd_state;
    next_wd_pre   = wd_pre;
    next_wd_count = wd_count;
    wd_warn       = 1'b0;
    wd_fault      = 1'b0;
    case (wd_state)
      timer_group_pkg::WD_OFF: begin
        next_wd_pre   = '0;
        next_wd_count = wd_period;
        if (ctrl.windowed_watchdog_en) begin
          next_wd_state = timer_group_pkg::WD_RUN;
        end
      end
      timer_group_pkg::WD_RUN: begin
        next_wd_pre = div_step(wd_pre, wd_div, edge_tick[ctrl.windowed_watchdog_clk_sel]);
        if (!ctrl.windowed_watchdog_en) begin
          next_wd_state = timer_group_pkg::WD_OFF;
        end else if (kick) begin
          if (ctrl.windowed_watchdog_win_en && wd_count > wd_window) begin
            wd_fault      = 1'b1;
            next_wd_state = timer_group_pkg::WD_TRIP;
          end else begin
            next_wd_pre   = '0;
            next_wd_count = wd_period;
          end
        end else if (wd_tick) begin
          if (wd_count == 24'h000000) begin
            next_wd_state = timer_group_pkg::WD_TRIP;
          end else begin
            next_wd_count = wd_count - 24'h000001;
            // Window opening doubles as interval or wake event
            wd_warn = (next_wd_count == wd_window);
          end
        end
      end
      timer_group_pkg::WD_TRIP: ;
      default: next_wd_state = timer_group_pkg::WD_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_fr      <= '0;
      sync_ro      <= '0;
      filt         <= '0;
      filt_d       <= '0;
      ms_cnt       <= '0;
      idle_ms      <= '0;
      afe_wd_reset <= 1'b0;
      wake_ms      <= '0;
      wake_pulse   <= 1'b0;
      rtc_pre      <= '0;
      usec         <= '0;
      tod          <= '0;
      wd_state     <= timer_group_pkg::WD_OFF;
      wd_pre       <= '0;
      wd_count     <= '0;
    end else begin
      sync_fr      <= {sync_fr[1:0], free_running_clock};
      sync_ro      <= {sync_ro[1:0], ring_oscillator_clock};
      filt         <= next_filt;
      filt_d       <= filt;
      ms_cnt       <= next_ms_cnt;
      idle_ms      <= next_idle_ms;
      afe_wd_reset <= next_afe_wd_reset;
      wake_ms      <= next_wake_ms;
      wake_pulse   <= next_wake_pulse;
      rtc_pre      <= next_rtc_pre;
      usec         <= next_usec;
      tod          <= next_tod;
      wd_state     <= next_wd_state;
      wd_pre       <= next_wd_pre;
      wd_count     <= next_wd_count;
    end
  end

  // General timers
  for (genvar g = 0; g < 2; g++) begin : g_gt
    down_counter #(
      .WIDTH (GT_WIDTH),
      .DIV_W (GT_DIV_W)
    ) u_gt (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (g == 0 ? ctrl.gt0_en : ctrl.gt1_en),
      .div     (gt_div[g]),
      .load    (gt_load[g]),
      .count   (gt_count[g]),
      .zero    (gt_zero[g])
    );
  end

endmodule : timer_group

// ---- core/timer_group_defs.svh ----
// Register map, register widths, reset values and timing figures of the timer group.
// Assumes a 100 MHz pclk; included by the timer group top and the bench.
`ifndef TIMER_GROUP_DEFS_SVH
`define TIMER_GROUP_DEFS_SVH

`define PCLK_NS         10
`define MS_NS           1000000
`define WAKE_BASE_MS    125
`define WAKE_SEL_MAX    3'h6
`define BUSWD_SHORT_MS  4000
`define BUSWD_LONG_MS   8000
`define RTC_US_PER_SEC  20'hF423F
`define RTC_SEC_MAX     6'h3B
`define RTC_MIN_MAX     6'h3B
`define RTC_HOUR_MAX    5'h17
`define WINDOWED_WATCHDOG_KEY        32'h0000A5C3

`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_RTC_DIV     12'h008
`define OFF_RTC_TIME    12'h00C
`define OFF_RTC_ALARM   12'h010
`define OFF_WINDOWED_WATCHDOG_DIV    12'h014
`define OFF_WINDOWED_WATCHDOG_PERIOD 12'h018
`define OFF_WINDOWED_WATCHDOG_WINDOW 12'h01C
`define OFF_WINDOWED_WATCHDOG_KICK   12'h020
`define OFF_GT0_LOAD    12'h024
`define OFF_GT0_DIV     12'h028
`define OFF_GT0_COUNT   12'h02C
`define OFF_GT1_LOAD    12'h030
`define OFF_GT1_DIV     12'h034
`define OFF_GT1_COUNT   12'h038
`define GT_STRIDE       12'h00C

`define CTRL_W          15
`define FLAGS_W         6
`define CTRL_RESET      15'h0000
`define WINDOWED_WATCHDOG_PERIOD_RST 24'hFFFFFF
`define WINDOWED_WATCHDOG_WINDOW_RST 24'hFFFFFF

`endif

// ---- core/timer_group_pkg.sv ----
// Types shared by the timer group: control word, status flags,
// calendar layout and watchdog states. Offsets live in the defs header.
package timer_group_pkg;

  typedef struct packed {
    logic       gt1_ie;
    logic       gt1_en;
    logic       gt0_ie;
    logic       gt0_en;
    logic       windowed_watchdog_ie;
    logic       windowed_watchdog_win_en;
    logic       windowed_watchdog_clk_sel;
    logic       windowed_watchdog_en;
    logic       rtc_alarm_ie;
    logic       rtc_en;
    logic [2:0] wake_sel;
    logic       wake_en;
    logic       bus_wd_long;
  } ctrl_t;

  typedef struct packed {
    logic windowed_watchdog_fault;
    logic gt1_zero;
    logic gt0_zero;
    logic windowed_watchdog_warn;
    logic rtc_alarm;
    logic wake;
  } flags_t;

  typedef struct packed {
    logic [6:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtc_time_t;

  typedef enum logic [1:0] {
    WD_OFF  = 2'b00,
    WD_RUN  = 2'b01,
    WD_TRIP = 2'b10
  } wd_state_t;

endpackage : timer_group_pkg

// ---- core/down_counter.sv ----
// One general count-down timer with its own prescaler.
// Assumes enable, divider and load value come from same-clock registers.
`timescale 1ns/100ps
module down_counter #(
  parameter int WIDTH = 24,
  parameter int DIV_W = 15
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             enable,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic [WIDTH-1:0] load,
  // State
  output logic      [WIDTH-1:0] count,
  output logic                  zero
);

  if (WIDTH < 1 || WIDTH > 32 || DIV_W < 1 || DIV_W > 16) begin : g_bad
    $error("down_counter: unsupported width");
  end

  logic [DIV_W-1:0] pre;
  logic [DIV_W-1:0] next_pre;
  logic [WIDTH-1:0] next_count;
  logic             next_zero;
  logic             tick;

  always_comb begin
    tick       = enable && (pre == div);
    next_pre   = pre;
    next_count = count;
    if (!enable) begin
      next_pre   = '0;
      next_count = load;
    end else begin
      next_pre = tick ? '0 : pre + 1'b1;
      if (tick) begin
        // Periodic: a zero count picks up the start value again
        next_count = (count == '0) ? load : count - 1'b1;
      end
    end
    next_zero = tick && (next_count == '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre   <= '0;
      count <= '0;
      zero  <= 1'b0;
    end else begin
      pre   <= next_pre;
      count <= next_count;
      zero  <= next_zero;
    end
  end

endmodule : down_counter

// ---- sim/timer_group_props.sv ----
// Checker for the timer group top: bus handshake and event outputs.
// Assumes it is bound onto timer_group with MS_CYCLES handed on.
`timescale 1ns/100ps
module timer_group_props #(
  parameter int MS_CYCLES = 100000
) (
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and events
  input wire logic        free_running_clock,
  input wire logic        ring_oscillator_clock,
  input wire logic        analog_front_end_access,
  input wire logic        afe_wd_reset,
  input wire logic        windowed_watchdog_por_req,
  input wire logic        wake_pulse,
  input wire logic        rtc_irq,
  input wire logic        windowed_watchdog_irq,
  input wire logic [1:0]  gt_irq
);
  // Cycles since the last front-end access
  int idle;
  int next_idle;
  always_comb next_idle = analog_front_end_access ? 0 : idle + 1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle <= 0;
    else idle <= next_idle;
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready)
    else $error("ready dropped");
  chk_slverr_unmapped: assert property (psel && penable && paddr > 12'h038 |-> pslverr)
    else $error("no error on unmapped access");
  chk_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  chk_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 12'h038 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (psel && !penable && !pwrite |=> ##1 $stable(prdata))
    else $error("read data moved after access");
  chk_busdog_sticky: assert property (afe_wd_reset |=> afe_wd_reset)
    else $error("bus watchdog reset dropped");
  chk_busdog_late: assert property ($rose(afe_wd_reset) |-> idle >= 4000 * MS_CYCLES - MS_CYCLES)
    else $error("bus watchdog fired early");
  chk_por_sticky: assert property (windowed_watchdog_por_req |=> windowed_watchdog_por_req)
    else $error("watchdog reset request dropped");
  chk_wake_single: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse longer than a cycle");
  chk_events_quiet: assert property ($rose(presetn) |-> !(afe_wd_reset || windowed_watchdog_por_req || wake_pulse || rtc_irq || windowed_watchdog_irq || |gt_irq))
    else $error("event active after reset");
endmodule : timer_group_props

bind timer_group timer_group_props #(.MS_CYCLES(MS_CYCLES)) i_timer_group_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .free_running_clock(free_running_clock), .ring_oscillator_clock(ring_oscillator_clock),
  .analog_front_end_access(analog_front_end_access), .afe_wd_reset(afe_wd_reset),
  .windowed_watchdog_por_req(windowed_watchdog_por_req), .wake_pulse(wake_pulse), .rtc_irq(rtc_irq),
  .windowed_watchdog_irq(windowed_watchdog_irq), .gt_irq(gt_irq));

// ---- sim/tb_top.sv ----
// Self-checking bench for the timer group: APB master, slow clock pins,
// bus activity pulses, event timing. Assumes the checker is bound in.
`timescale 1ns/100ps
`include "timer_group_defs.svh"
module tb_top;
  localparam int MS = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, access_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        free_running_clock, ring_oscillator_clock, analog_front_end_access;
  logic        afe_wd_reset, windowed_watchdog_por_req, wake_pulse, rtc_irq, windowed_watchdog_irq;
  logic [1:0]  gt_irq;
  logic [32:0] exp_q[$];
  int          failures, total_checks, cyc, last_acc, rst_t;
  logic [11:0] offs[9] = '{`OFF_RTC_DIV, `OFF_RTC_ALARM, `OFF_WINDOWED_WATCHDOG_DIV, `OFF_WINDOWED_WATCHDOG_PERIOD,
                           `OFF_WINDOWED_WATCHDOG_WINDOW, `OFF_GT0_LOAD, `OFF_GT0_DIV, `OFF_GT1_LOAD,
                           `OFF_GT1_DIV};
  logic [31:0] msks[9] = '{32'hFFFF, 32'hFFFFFF, 32'hFFFF, 32'hFFFFFF, 32'hFFFFFF,
                           32'hFFFFFF, 32'h7FFF, 32'hFFFFFF, 32'h7FFF};

  timer_group #(.MS_CYCLES(MS)) i_timer_group (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .free_running_clock(free_running_clock), .ring_oscillator_clock(ring_oscillator_clock),
    .analog_front_end_access(analog_front_end_access), .afe_wd_reset(afe_wd_reset),
    .windowed_watchdog_por_req(windowed_watchdog_por_req), .wake_pulse(wake_pulse), .rtc_irq(rtc_irq),
    .windowed_watchdog_irq(windowed_watchdog_irq), .gt_irq(gt_irq));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Slow clocks keep each phase at least 3 cycles so the synchronisers see them
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    free_running_clock <= cyc[2];
    ring_oscillator_clock <= (cyc % 10) < 5;
    analog_front_end_access <= access_on && cyc[7:0] == 8'h00;
    if (access_on && cyc[7:0] == 8'h00) last_acc <= int'($time / 10);
  end

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, exp_q.pop_front());

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check(33'h0, 33'h1);
      end_sim();
    end
    // Idle edge so a following call never rewrites psel in this time step
    @(posedge pclk);
  endtask : apb_xfer

  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : apb_wr

  task automatic apb_rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb_xfer(1'b0, a, 32'h0);
  endtask : apb_rd

  function automatic logic sig(input int w);
    case (w)
      0: return gt_irq[0];
      1: return gt_irq[1];
      2: return wake_pulse;
      3: return windowed_watchdog_irq;
      4: return windowed_watchdog_por_req;
      default: return afe_wd_reset;
    endcase
  endfunction : sig

  task automatic wait_hi(input int w, input int bound, output int t);
    int n;
    for (n = 0; n < bound; n++) begin
      @(posedge pclk);
      if (sig(w) === 1'b1) break;
    end
    t = int'($time / 10);
    if (n >= bound) begin
      failures++;
      $display("mismatch at %0t: event %h never came, expected %h", $time, w, 1);
      end_sim();
    end
  endtask : wait_hi

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rst_t = int'($time / 10);
  endtask : do_reset

  initial begin
    int t0, t1;
    logic [31:0] d;
    logic [11:0] base;
    {psel, penable, pwrite, paddr, pwdata, free_running_clock} = '0;
    {ring_oscillator_clock, analog_front_end_access, presetn} = '0;
    access_on = 1'b1;
    {cyc, last_acc, failures, total_checks} = '0;
    void'($urandom(21));
    do_reset();
    apb_rd(`OFF_CTRL, 33'h0);
    apb_rd(`OFF_WINDOWED_WATCHDOG_PERIOD, 33'hFFFFFF);
    apb_rd(`OFF_WINDOWED_WATCHDOG_WINDOW, 33'hFFFFFF);
    apb_rd(12'h03C, 33'h100000000);
    apb_wr(`OFF_RTC_TIME, 32'h123);
    apb_rd(`OFF_RTC_TIME, 33'h0);
    for (int i = 0; i < 9; i++) begin
      d = $urandom();
      apb_wr(offs[i], d);
      apb_rd(offs[i], {1'b0, d & msks[i]});
    end
    d = $urandom() & 32'h7F7F;
    apb_wr(`OFF_CTRL, d);
    apb_rd(`OFF_CTRL, {1'b0, d});
    for (int g = 0; g < 2; g++) begin
      base = `OFF_GT0_LOAD + `GT_STRIDE * 12'(g);
      apb_wr(`OFF_CTRL, 32'h0);
      apb_wr(`OFF_STATUS, 32'h3F);
      apb_wr(base, 32'h5);
      apb_wr(base + 12'h004, 32'h2);
      apb_wr(`OFF_CTRL, 32'h800 << (2 * g));
      repeat (40) @(posedge pclk);
      check({32'h0, gt_irq[g]}, 33'h0);
      check({32'h0, rtc_irq}, 33'h0);
      apb_rd(`OFF_STATUS, {1'b0, 32'h8 << g});
      apb_wr(`OFF_CTRL, 32'h0);
      apb_rd(base + 12'h008, 33'h5);
      apb_wr(`OFF_STATUS, 32'h3F);
      apb_wr(`OFF_CTRL, 32'h1800 << (2 * g));
      wait_hi(g, 200, t0);
      apb_wr(`OFF_STATUS, 32'h8 << g);
      wait_hi(g, 200, t1);
      check(33'(t1 - t0), 33'h12);
    end
    apb_wr(`OFF_CTRL, 32'h0);
    apb_wr(`OFF_STATUS, 32'h3F);
    for (int s = 0; s < 2; s++) begin
      apb_wr(`OFF_CTRL, 32'h2 | (32'(s) << 2));
      wait_hi(2, 9000, t0);
      wait_hi(2, 9000, t0);
      wait_hi(2, 9000, t1);
      check(33'(t1 - t0), 33'(125 * MS << s));
    end
    apb_rd(`OFF_STATUS, 33'h1);
    apb_wr(`OFF_CTRL, 32'h0);
    apb_wr(`OFF_STATUS, 32'h3F);
    apb_wr(`OFF_WINDOWED_WATCHDOG_PERIOD, 32'h14);
    apb_wr(`OFF_WINDOWED_WATCHDOG_WINDOW, 32'h0A);
    apb_wr(`OFF_WINDOWED_WATCHDOG_DIV, 32'h0);
    apb_wr(`OFF_CTRL, 32'h680);
    wait_hi(3, 400, t0);
    apb_wr(`OFF_WINDOWED_WATCHDOG_KICK, `WINDOWED_WATCHDOG_KEY);
    t0 = int'($time / 10);
    wait_hi(4, 400, t1);
    check(33'(t1 - t0 > 150 && t1 - t0 < 190), 33'h1);
    apb_rd(`OFF_STATUS, 33'h4);
    do_reset();
    apb_wr(`OFF_WINDOWED_WATCHDOG_PERIOD, 32'h14);
    apb_wr(`OFF_WINDOWED_WATCHDOG_WINDOW, 32'h0A);
    apb_wr(`OFF_CTRL, 32'h780);
    apb_wr(`OFF_WINDOWED_WATCHDOG_KICK, `WINDOWED_WATCHDOG_KEY);
    wait_hi(4, 10, t1);
    apb_rd(`OFF_STATUS, 33'h20);
    do_reset();
    access_on <= 1'b0;
    wait_hi(5, 41000, t1);
    t0 = (rst_t > last_acc) ? rst_t : last_acc;
    check(33'(t1 - t0 > 39980 && t1 - t0 < 40030), 33'h1);
    end_sim();
  end
endmodule : tb_top
